/* File: core/grb_bank.sv */
// register bank: gauge readback and moisture adc configuration
//
// Behaviour
// (RULE_01) charge is high and low byte joined
// (RULE_02) time to full is bytes joined
// (RULE_03) readback bytes read-only, zero, gauge-fed
// (RULE_04) five reliability flags in bits 4:0
// (RULE_05) bit5 sniffer enable, bit7 port ready
// (RULE_06) retry count field, reset one
// (RULE_07) retry: saturated, 1uA, average below margin
// (RULE_08) retry: saturated at other currents
// (RULE_09) abort when retries are used up
// (RULE_10) six-bit shift factor, reset nine
// (RULE_11) software keeps shift factor at least nine
// (RULE_12) averaging count is two to field
// (RULE_13) averaging applies to all resistive readings
// (RULE_14) ground threshold bits 6:3, reset four
// (RULE_15) software leaves noise margin at default
// (RULE_16) pull-up current two-bit code
// (RULE_17) retry counter clears per request
`timescale 1ns/1ps
module grb_bank (
    input  wire logic                 I_CLK,         // 10 MHz clock
    input  wire logic                 I_RSTN,        // async reset, low
    input  wire logic [7:0]           I_ADDR,        // register address
    input  wire logic [7:0]           I_WDATA,       // write data
    input  wire logic                 I_WR,          // write strobe
    input  wire logic                 I_RD,          // read strobe
    output logic      [7:0]           O_RDATA,       // read data, next cycle
    input  wire grb_pkg::grb_gauge_t  I_GAUGE,       // fuel gauge outputs
    input  wire logic                 I_MEAS_START,  // measurement request
    input  wire logic                 I_SAMPLE_VLD,  // reading finished
    input  wire grb_pkg::grb_sample_t I_SAMPLE,      // reading max and avg
    output grb_pkg::grb_adc_cfg_t     O_ADC_CFG,     // adc configuration
    output logic      [7:0]           O_AVG_COUNT,   // samples per reading
    output logic                      O_SNIFF_EN,    // port sniffer enable
    output logic                      O_RETRY,       // pulse: measure again
    output logic                      O_MEAS_DONE,   // pulse: outcome ready
    output logic                      O_ABORT,       // last outcome abort
    output logic                      O_IRQ          // interrupt, high active
);
    import grb_pkg::*;

    logic [15:0]        soc_q;
    logic [15:0]        ttf_q;
    logic [4:0]         rel_q;
    logic               port_rdy_q;
    logic               sniff_q;
    logic [3:0]         gnd_q;
    logic [2:0]         rty_q;
    logic [5:0]         shift_q;
    logic [2:0]         avg_q;
    logic [5:0]         noise_q;
    logic [1:0]         pull_q;
    logic [IRQ_W-1:0]   stat_q;
    logic [IRQ_W-1:0]   stat_d;
    logic [IRQ_W-1:0]   mask_q;
    logic [IRQ_W-1:0]   events;
    logic [7:0]         rdata_q;
    logic [7:0]         rd_mux;
    logic               again;
    logic               done;
    grb_result_t        result;
    logic               wr_gnd;
    logic               wr_shift;
    logic               wr_avg;
    logic               wr_noise;
    logic               wr_pull;
    logic               wr_flags;
    logic               wr_mask;
    logic               rd_stat;
    logic               sat_w;

    // write decode
    assign wr_flags = I_WR && (I_ADDR == OFF_FLAGS);
    assign wr_gnd   = I_WR && (I_ADDR == OFF_GND_RETRY);
    assign wr_shift = I_WR && (I_ADDR == OFF_SHIFT);
    assign wr_avg   = I_WR && (I_ADDR == OFF_AVERAGE);
    assign wr_noise = I_WR && (I_ADDR == OFF_NOISE);
    assign wr_pull  = I_WR && (I_ADDR == OFF_PULLUP);
    assign wr_mask  = I_WR && (I_ADDR == OFF_IRQ_MASK);
    assign rd_stat  = I_RD && (I_ADDR == OFF_IRQ_STATUS);

    grb_retry_ctl u_retry (
        .I_CLK     (I_CLK),
        .I_RSTN    (I_RSTN),
        .i_start   (I_MEAS_START),
        .i_retries (rty_q),
        .i_pullup  (pull_q),
        .i_noise   (noise_q),
        .i_valid   (I_SAMPLE_VLD),
        .i_sample  (I_SAMPLE),
        .o_again   (again),
        .o_done    (done),
        .o_result  (result)
    );

    // (RULE_03) gauge bytes are loaded only from gauge
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            soc_q      <= 16'h0000;
            ttf_q      <= 16'h0000;
            rel_q      <= 5'h00;
            port_rdy_q <= 1'b0;
        end else if (I_GAUGE.update) begin
            // (RULE_01) whole 16-bit charge word
            soc_q      <= I_GAUGE.soc;
            // (RULE_02) whole 16-bit time word
            ttf_q      <= I_GAUGE.ttf;
            // (RULE_04) reliability from gauge
            rel_q      <= I_GAUGE.reliable;
            port_rdy_q <= I_GAUGE.port_ready;
        end
    end

    // configuration registers
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sniff_q <= RST_SNIFF_EN;
            gnd_q   <= RST_GND_THR;
            rty_q   <= RST_RETRY;
            shift_q <= RST_SHIFT;
            avg_q   <= RST_AVERAGE;
            noise_q <= RST_NOISE;
            pull_q  <= RST_PULLUP;
            mask_q  <= '0;
        end else begin
            // (RULE_05) only the enable bit is writable
            if (wr_flags) begin
                sniff_q <= I_WDATA[FLG_SNIFF_EN];
            end
            // (RULE_14) threshold and retry fields
            if (wr_gnd) begin
                gnd_q <= I_WDATA[GND_MSB:GND_LSB];
                rty_q <= I_WDATA[RTY_MSB:0];
            end
            // (RULE_10) values below nine stored as written
            if (wr_shift) begin
                shift_q <= I_WDATA[5:0];
            end
            if (wr_avg) begin
                avg_q <= I_WDATA[2:0];
            end
            if (wr_noise) begin
                noise_q <= I_WDATA[5:0];
            end
            if (wr_pull) begin
                pull_q <= I_WDATA[1:0];
            end
            if (wr_mask) begin
                mask_q <= I_WDATA[IRQ_W-1:0];
            end
        end
    end

    // sticky status: a new event beats the clear-on-read
    assign events[IRQ_DONE]  = done;
    // (RULE_09) final reading still saturated: abort now, not last outcome
    assign sat_w = (I_SAMPLE.max_val == ADC_FULL)
                 && ((pull_q != PULLUP_1UA)
                 || (I_SAMPLE.avg_val < (ADC_FULL - {2'h0, noise_q})));
    assign events[IRQ_ABORT] = done && sat_w;
    assign events[IRQ_GAUGE] = I_GAUGE.update;
    assign stat_d = (rd_stat ? '0 : stat_q) | events;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (I_ADDR)
            OFF_SOC_HIGH:   rd_mux = soc_q[15:8];
            OFF_SOC_LOW:    rd_mux = soc_q[7:0];
            OFF_TTF_HIGH:   rd_mux = ttf_q[15:8];
            OFF_TTF_LOW:    rd_mux = ttf_q[7:0];
            OFF_FLAGS:      rd_mux = {port_rdy_q, 1'b0, sniff_q, rel_q};
            OFF_GND_RETRY:  rd_mux = {1'b0, gnd_q, rty_q};
            OFF_SHIFT:      rd_mux = {2'h0, shift_q};
            OFF_AVERAGE:    rd_mux = {5'h00, avg_q};
            OFF_NOISE:      rd_mux = {2'h0, noise_q};
            OFF_PULLUP:     rd_mux = {6'h00, pull_q};
            OFF_MEAS_CTRL:  rd_mux = {6'h00, result};
            OFF_IRQ_STATUS: rd_mux = {5'h00, stat_q};
            OFF_IRQ_MASK:   rd_mux = {5'h00, mask_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_q <= 8'h00;
        end else if (I_RD) begin
            rdata_q <= rd_mux;
        end
    end

    assign O_RDATA = rdata_q;
    assign O_ADC_CFG.ground_level_threshold   = gnd_q;
    assign O_ADC_CFG.measurement_shift_factor = shift_q;
    assign O_ADC_CFG.sample_average_select    = avg_q;
    assign O_ADC_CFG.noise_margin_setting     = noise_q;
    assign O_ADC_CFG.pullup_current_select    = pull_q;
    // (RULE_12) two to the field, 1 to 128
    // (RULE_13) one count for every resistive reading
    assign O_AVG_COUNT = 8'h01 << avg_q;
    assign O_SNIFF_EN  = sniff_q;
    assign O_RETRY     = again;
    assign O_MEAS_DONE = done;
    assign O_ABORT     = (result == RES_ABORT);
    assign O_IRQ       = |(stat_q & mask_q);
endmodule : grb_bank

/* File: inc/grb_pkg.sv */
// package for gauge readback and moisture adc configuration bank
package grb_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    // register offsets
    localparam logic [7:0]  OFF_SOC_HIGH     = 8'h66;
    localparam logic [7:0]  OFF_SOC_LOW      = 8'h67;
    localparam logic [7:0]  OFF_TTF_HIGH     = 8'h68;
    localparam logic [7:0]  OFF_TTF_LOW      = 8'h69;
    localparam logic [7:0]  OFF_FLAGS        = 8'h6A;
    localparam logic [7:0]  OFF_GND_RETRY    = 8'h70;
    localparam logic [7:0]  OFF_SHIFT        = 8'h71;
    localparam logic [7:0]  OFF_AVERAGE      = 8'h72;
    localparam logic [7:0]  OFF_NOISE        = 8'h73;
    localparam logic [7:0]  OFF_PULLUP       = 8'h74;
    localparam logic [7:0]  OFF_MEAS_CTRL    = 8'h7C;
    localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h7D;
    localparam logic [7:0]  OFF_IRQ_MASK     = 8'h7E;
    // field positions
    localparam int          FLG_TTF          = 4;
    localparam int          FLG_SOC          = 3;
    localparam int          FLG_TTE          = 2;
    localparam int          FLG_VCELL        = 1;
    localparam int          FLG_AVGV         = 0;
    localparam int          FLG_SNIFF_EN     = 5;
    localparam int          FLG_PORT_RDY     = 7;
    localparam int          GND_LSB          = 3;
    localparam int          GND_MSB          = 6;
    localparam int          RTY_MSB          = 2;
    // reset values, adc full-scale code and 1uA pull-up code
    localparam logic        RST_SNIFF_EN     = 1'b1;
    localparam logic [3:0]  RST_GND_THR      = 4'h4;
    localparam logic [2:0]  RST_RETRY        = 3'h1;
    localparam logic [5:0]  RST_SHIFT        = 6'h09;
    localparam logic [2:0]  RST_AVERAGE      = 3'h0;
    localparam logic [5:0]  RST_NOISE        = 6'h00;
    localparam logic [1:0]  RST_PULLUP       = 2'h0;
    localparam logic [7:0]  ADC_FULL         = 8'hFF;
    localparam logic [1:0]  PULLUP_1UA       = 2'h0;
    // interrupt status bits
    localparam int          IRQ_DONE         = 0;
    localparam int          IRQ_ABORT        = 1;
    localparam int          IRQ_GAUGE        = 2;
    localparam int          IRQ_W            = 3;

    typedef enum logic [1:0] {
        RES_NONE,
        RES_OK,
        RES_ABORT
    } grb_result_t;

    typedef struct packed {
        logic [15:0] soc;
        logic [15:0] ttf;
        logic [4:0]  reliable;
        logic        port_ready;
        logic        update;
    } grb_gauge_t;

    typedef struct packed {
        logic [7:0]  max_val;
        logic [7:0]  avg_val;
    } grb_sample_t;

    typedef struct packed {
        logic [3:0]  ground_level_threshold;
        logic [5:0]  measurement_shift_factor;
        logic [2:0]  sample_average_select;
        logic [5:0]  noise_margin_setting;
        logic [1:0]  pullup_current_select;
    } grb_adc_cfg_t;
endpackage : grb_pkg

/* File: core/grb_retry_ctl.sv */
// retry sequencer for one resistive measurement
`timescale 1ns/1ps
module grb_retry_ctl (
    input  wire logic                I_CLK,      // system clock
    input  wire logic                I_RSTN,     // async reset, low
    input  wire logic                i_start,    // new measurement request
    input  wire logic [2:0]          i_retries,  // configured retry count
    input  wire logic [1:0]          i_pullup,   // pull-up current code
    input  wire logic [5:0]          i_noise,    // noise clamp margin
    input  wire logic                i_valid,    // one reading finished
    input  wire grb_pkg::grb_sample_t i_sample,  // reading max and avg
    output logic                     o_again,    // pulse: take reading again
    output logic                     o_done,     // pulse: outcome ready
    output grb_pkg::grb_result_t     o_result    // registered outcome
);
    import grb_pkg::*;

    logic [2:0]  used_q;
    logic [2:0]  used_d;
    logic        cond1;
    logic        cond2;
    logic        need_retry;
    logic        room;
    logic [7:0]  limit;
    grb_result_t result_q;

    assign limit = ADC_FULL - {2'h0, i_noise};
    // (RULE_07) saturated at lowest current
    assign cond1 = (i_sample.max_val == ADC_FULL)
                 && (i_pullup == PULLUP_1UA)
                 && (i_sample.avg_val < limit);
    // (RULE_08) saturated at higher current
    assign cond2 = (i_sample.max_val == ADC_FULL)
                 && (i_pullup != PULLUP_1UA);
    // (RULE_16) code zero is one microamp
    assign need_retry = cond1 || cond2;
    // (RULE_06) zero count means no retry
    assign room    = used_q < i_retries;
    assign o_again = i_valid && need_retry && room;
    assign o_done  = i_valid && !(need_retry && room);
    // (RULE_17) counter restarts per request
    assign used_d  = i_start ? 3'h0
                   : (o_again ? used_q + 3'h1 : used_q);
    assign o_result = result_q;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            used_q   <= 3'h0;
            result_q <= RES_NONE;
        end else begin
            used_q <= used_d;
            // (RULE_09) exhausted retries give abort
            if (o_done) begin
                result_q <= need_retry ? RES_ABORT : RES_OK;
            end
        end
    end
endmodule : grb_retry_ctl

/* File: verif/grb_bank_asserts.sv */
// port assertions for the gauge readback and adc configuration bank
`timescale 1ns/1ps
module grb_bank_asserts (
    input wire logic                  I_CLK,        // clock
    input wire logic                  I_RSTN,       // async reset, low
    input wire logic [7:0]            I_ADDR,       // address
    input wire logic [7:0]            I_WDATA,      // write data
    input wire logic                  I_WR,         // write strobe
    input wire logic                  I_RD,         // read strobe
    input wire logic [7:0]            O_RDATA,      // read data
    input wire grb_pkg::grb_gauge_t   I_GAUGE,      // gauge outputs
    input wire logic                  I_SAMPLE_VLD, // reading done
    input wire grb_pkg::grb_sample_t  I_SAMPLE,     // max and avg
    input wire grb_pkg::grb_adc_cfg_t O_ADC_CFG,    // adc config
    input wire logic [7:0]            O_AVG_COUNT,  // samples
    input wire logic                  O_SNIFF_EN,   // sniffer enable
    input wire logic                  O_RETRY,      // retry pulse
    input wire logic                  O_MEAS_DONE,  // done pulse
    input wire logic                  O_ABORT       // abort level
);
    import grb_pkg::*;
    logic [15:0] soc_q;
    logic [15:0] ttf_q;
    // saturated reading that still asks for another try
    wire logic cond_w = (I_SAMPLE.max_val == ADC_FULL) &&
        ((O_ADC_CFG.pullup_current_select != PULLUP_1UA) ||
         (I_SAMPLE.avg_val <
          (ADC_FULL - {2'h0, O_ADC_CFG.noise_margin_setting})));
    // shadow of the gauge values, loaded only on update
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            soc_q <= 16'h0000;
            ttf_q <= 16'h0000;
        end else if (I_GAUGE.update) begin
            soc_q <= I_GAUGE.soc;
            ttf_q <= I_GAUGE.ttf;
        end
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    a_avg_power: assert property (
        O_AVG_COUNT == (8'h01 << O_ADC_CFG.sample_average_select))
        else $error("average count not a power of two of field");
    a_retry_cause: assert property (
        O_RETRY |-> I_SAMPLE_VLD && cond_w)
        else $error("retry without a saturated reading");
    a_one_answer: assert property (
        I_SAMPLE_VLD |-> O_RETRY != O_MEAS_DONE)
        else $error("reading gave no single answer");
    a_clean_done: assert property (
        I_SAMPLE_VLD && !cond_w |-> O_MEAS_DONE)
        else $error("clean reading did not finish");
    a_abort_set: assert property (
        O_MEAS_DONE && cond_w |=> O_ABORT)
        else $error("exhausted retries not reported as abort");
    a_ok_clear: assert property (
        O_MEAS_DONE && !cond_w |=> !O_ABORT)
        else $error("good outcome reported as abort");
    a_abort_hold: assert property (
        !O_MEAS_DONE |=> $stable(O_ABORT))
        else $error("outcome changed without a finish");
    a_shift_write: assert property (
        I_WR && I_ADDR == OFF_SHIFT |=>
        {2'h0, O_ADC_CFG.measurement_shift_factor} ==
        ($past(I_WDATA) & 8'h3F))
        else $error("shift factor not taken from write");
    a_gnd_write: assert property (
        I_WR && I_ADDR == OFF_GND_RETRY |=>
        {4'h0, O_ADC_CFG.ground_level_threshold} ==
        (($past(I_WDATA) >> 3) & 8'h0F))
        else $error("ground threshold not taken from write");
    a_sniff_write: assert property (
        I_WR && I_ADDR == OFF_FLAGS |=>
        {7'h0, O_SNIFF_EN} == (($past(I_WDATA) >> 5) & 8'h01))
        else $error("sniffer enable not taken from write");
    a_ttf_read: assert property (
        I_RD && I_ADDR == OFF_TTF_HIGH && !I_GAUGE.update |=>
        O_RDATA == ttf_q[15:8])
        else $error("time to full high byte read wrong");
    a_soc_read: assert property (
        I_RD && I_ADDR == OFF_SOC_LOW && !I_GAUGE.update |=>
        O_RDATA == soc_q[7:0])
        else $error("charge low byte read wrong");
endmodule : grb_bank_asserts
bind grb_bank grb_bank_asserts grb_bank_asserts_i (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_GAUGE(I_GAUGE),
    .I_SAMPLE_VLD(I_SAMPLE_VLD), .I_SAMPLE(I_SAMPLE),
    .O_ADC_CFG(O_ADC_CFG), .O_AVG_COUNT(O_AVG_COUNT),
    .O_SNIFF_EN(O_SNIFF_EN), .O_RETRY(O_RETRY),
    .O_MEAS_DONE(O_MEAS_DONE), .O_ABORT(O_ABORT));

/* File: verif/tb.sv */
// self-checking bench for the gauge readback and adc configuration bank
`timescale 1ns/1ps
module tb;
    import grb_pkg::*;
    logic         I_CLK = 1'b0, I_RSTN = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic         I_MEAS_START = 1'b0, I_SAMPLE_VLD = 1'b0;
    logic [7:0]   I_ADDR = 8'h00, I_WDATA = 8'h00, O_RDATA, O_AVG_COUNT;
    grb_gauge_t   I_GAUGE = '0;
    grb_sample_t  I_SAMPLE = '0;
    grb_adc_cfg_t O_ADC_CFG;
    logic         O_SNIFF_EN, O_RETRY, O_MEAS_DONE, O_ABORT, O_IRQ;
    int           err_count = 0;
    int           checks = 0;
    logic [7:0]   ra [11] = '{8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h70,
                              8'h71, 8'h72, 8'h73, 8'h74, 8'h50};
    logic [7:0]   rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h21,
                              8'h09, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]   gv [5]  = '{8'hA5, 8'h5A, 8'h12, 8'h34, 8'hB5};
    always #50 I_CLK = ~I_CLK;
    grb_bank grb_bank_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .I_GAUGE(I_GAUGE), .I_MEAS_START(I_MEAS_START),
        .I_SAMPLE_VLD(I_SAMPLE_VLD), .I_SAMPLE(I_SAMPLE),
        .O_ADC_CFG(O_ADC_CFG), .O_AVG_COUNT(O_AVG_COUNT),
        .O_SNIFF_EN(O_SNIFF_EN), .O_RETRY(O_RETRY),
        .O_MEAS_DONE(O_MEAS_DONE), .O_ABORT(O_ABORT), .O_IRQ(O_IRQ));
    task automatic chk(input string w, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), O_RDATA, e);
    endtask : rd
    // start clears the retry count, so config goes in first
    task automatic meas(input logic [2:0] r, input logic [1:0] p,
                        input logic [5:0] n);
        wr(OFF_GND_RETRY, {1'b0, 4'h4, r});
        wr(OFF_PULLUP, {6'h0, p});
        wr(OFF_NOISE, {2'h0, n});
        @(posedge I_CLK);
        I_MEAS_START <= 1'b1;
        @(posedge I_CLK);
        I_MEAS_START <= 1'b0;
    endtask : meas
    // pulses are combinational, so look inside the valid cycle
    task automatic samp(input logic [7:0] mx, av, input logic [1:0] e);
        @(posedge I_CLK);
        I_SAMPLE <= {mx, av};
        I_SAMPLE_VLD <= 1'b1;
        #1;
        chk("retry_done", {6'h0, O_RETRY, O_MEAS_DONE}, {6'h0, e});
        @(posedge I_CLK);
        I_SAMPLE_VLD <= 1'b0;
    endtask : samp
    task automatic abt(input logic e);
        #1;
        chk("abort", {7'h0, O_ABORT}, {7'h0, e});
    endtask : abt
    task automatic bit1(input string w, input logic s, e);
        chk(w, {7'h0, s}, {7'h0, e});
    endtask : bit1
    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            rd(ra[k], rv[k]);
        end
        chk("avg_count", O_AVG_COUNT, 8'h01);
        bit1("sniff", O_SNIFF_EN, 1'b1);
        for (int k = 0; k < 5; k++) begin
            wr(ra[k], 8'hFF);
        end
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], rv[k]);
        end
        wr(OFF_FLAGS, 8'h00);
        rd(OFF_FLAGS, 8'h00);
        bit1("sniff", O_SNIFF_EN, 1'b0);
        wr(OFF_FLAGS, 8'h20);
        @(posedge I_CLK);
        I_GAUGE <= {16'hA55A, 16'h1234, 5'h15, 1'b1, 1'b1};
        @(posedge I_CLK);
        I_GAUGE <= {16'h0F0F, 16'h0F0F, 5'h0A, 1'b0, 1'b0};
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], gv[k]);
        end
        rd(OFF_IRQ_STATUS, 8'h04);
        rd(OFF_IRQ_STATUS, 8'h00);
        wr(OFF_IRQ_MASK, 8'h02);
        meas(3'h0, 2'h1, 6'h00);
        samp(8'hFF, 8'h00, 2'b01);
        abt(1'b1);
        bit1("irq", O_IRQ, 1'b1);
        rd(OFF_MEAS_CTRL, 8'h02);
        rd(OFF_IRQ_STATUS, 8'h03);
        bit1("irq", O_IRQ, 1'b0);
        meas(3'h1, 2'h1, 6'h00);
        samp(8'hFF, 8'h00, 2'b10);
        samp(8'hFF, 8'h00, 2'b01);
        abt(1'b1);
        rd(OFF_IRQ_STATUS, 8'h03);
        meas(3'h1, 2'h0, 6'h00);
        samp(8'hFF, 8'hFE, 2'b10);
        samp(8'hFF, 8'hFF, 2'b01);
        abt(1'b0);
        meas(3'h1, 2'h0, 6'h00);
        samp(8'hFF, 8'hFF, 2'b01);
        abt(1'b0);
        rd(OFF_MEAS_CTRL, 8'h01);
        rd(OFF_IRQ_STATUS, 8'h01);
        meas(3'h1, 2'h0, 6'h00);
        samp(8'hFF, 8'hF9, 2'b10);
        samp(8'h20, 8'h00, 2'b01);
        bit1("irq", O_IRQ, 1'b0);
        meas(3'h2, 2'h3, 6'h00);
        samp(8'hFF, 8'h00, 2'b10);
        meas(3'h2, 2'h3, 6'h00);
        samp(8'hFF, 8'h00, 2'b10);
        samp(8'hFF, 8'h00, 2'b10);
        samp(8'hFF, 8'h00, 2'b01);
        abt(1'b1);
        for (int p = 0; p < 4; p++) begin
            meas(3'h0, p[1:0], 6'h00);
            samp(8'hFF, 8'hFF, 2'b01);
            abt(p != 0);
            chk("pullup", {6'h0, O_ADC_CFG.pullup_current_select}, p[7:0]);
        end
        for (int k = 0; k < 8; k++) begin
            wr(OFF_AVERAGE, k[7:0]);
            rd(OFF_AVERAGE, k[7:0]);
            chk("avg_count", O_AVG_COUNT, 8'h01 << k);
        end
        wr(OFF_GND_RETRY, 8'h53);
        rd(OFF_GND_RETRY, 8'h53);
        chk("gnd", {4'h0, O_ADC_CFG.ground_level_threshold}, 8'h0A);
        wr(OFF_SHIFT, 8'h3F);
        rd(OFF_SHIFT, 8'h3F);
        tally_and_finish();
    end
endmodule : tb
